// ==== src/sbt_defs.svh ====
// Constants for the serial busy-cycle tracker, both link ends.
// Assumes one SPI-style word per chip-select frame, MSB first.
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// ============================================================
// Word layout
`define SBT_CH_W 2
`define SBT_ADDR_W 7
`define SBT_DATA_W 16
`define SBT_WORD_BITS 5'h1A
`define SBT_BITS_OVER 5'h1B
`define SBT_CH_NONE 2'h0
`define SBT_CH_BOTH 2'h3

// ============================================================
// Address decode
`define SBT_LVL_FIRST 7'h01
`define SBT_LVL_LAST 7'h0E
`define SBT_CTRL_ADDR 7'h12
`define SBT_SRST_BIT 0

// ============================================================
// Busy lengths in rising serial-clock edges
`define SBT_CNT_W 7
`define SBT_ONE_CYC 7'h01
`define SBT_RST_CYC 7'h40
`define SBT_STD_CYC 7'h03
`define SBT_SGL_NOCAL 7'h0A
`define SBT_DBL_NOCAL 7'h10
`define SBT_SGL_CAL 7'h14
`define SBT_DBL_CAL 7'h1A

// ============================================================
// Host timing
`define SBT_SCLK_PERIOD_NS 32'h50
`define SBT_SYS_PERIOD_NS 32'h8
`define SBT_SCLK_HALF_CYC \
	((`SBT_SCLK_PERIOD_NS / `SBT_SYS_PERIOD_NS) / 32'h2)
`define SBT_REASSERT_MIN 7'h04
`define SBT_HRST_EDGES 7'h02

`endif

// ==== src/sbt_pkg.sv ====
// Types and the shared busy-length decode of the tracker.
// Assumes the constants header is on the include path.
`include "sbt_defs.svh"

package sbt_pkg;

	// ============================================================
	// Instruction word, transmitted from the top bit down
	typedef struct packed {
		logic rd;
		logic [`SBT_CH_W-1:0] ch;
		logic [`SBT_ADDR_W-1:0] addr;
		logic [`SBT_DATA_W-1:0] data;
	} sbt_instr_t;

	typedef enum logic [1:0] {
		SBT_D_IDLE = 2'b00,
		SBT_D_RESET = 2'b01,
		SBT_D_BUSY = 2'b10
	} sbt_dev_st_t;

	typedef enum logic [2:0] {
		SBT_H_IDLE = 3'b000,
		SBT_H_RSTHOLD = 3'b001,
		SBT_H_LOAD = 3'b010,
		SBT_H_SHIFT = 3'b011,
		SBT_H_RECOVER = 3'b100
	} sbt_host_st_t;

	// ============================================================
	// Busy length of one instruction
	function automatic logic [`SBT_CNT_W-1:0] sbt_busy_cycles(
		input sbt_instr_t w,
		input logic cal
	);
		logic lvl;
		lvl = (w.addr >= `SBT_LVL_FIRST) && (w.addr <= `SBT_LVL_LAST);
		if (!w.rd && w.addr == `SBT_CTRL_ADDR && w.data[`SBT_SRST_BIT])
			return `SBT_RST_CYC;
		if (w.rd || !lvl || w.ch == `SBT_CH_NONE)
			return `SBT_STD_CYC;
		if (w.ch == `SBT_CH_BOTH)
			return cal ? `SBT_DBL_CAL : `SBT_DBL_NOCAL;
		return cal ? `SBT_SGL_CAL : `SBT_SGL_NOCAL;
	endfunction

endpackage

// ==== src/sbt_if.sv ====
// Link between host and tracker: clock, select, data, reset, busy.
// Busy is open drain with a pull-up, resolved here from the enable.
interface sbt_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic hw_rst_n;
	logic busy_o;
	logic busy_oe;
	logic busy_n;

	// Pull-up wins unless the device sinks the line
	assign busy_n = (busy_oe && !busy_o) ? 1'b0 : 1'b1;

	modport dev (
		input sclk,
		input cs_n,
		input sdi,
		input hw_rst_n,
		output busy_o,
		output busy_oe
	);

	modport host (
		output sclk,
		output cs_n,
		output sdi,
		output hw_rst_n,
		input busy_n
	);
endinterface

// ==== src/sbt_dev.sv ====
// Device end: receives instruction frames and drives open-drain busy.
// Runs only on the serial clock; its reset pin is sampled on it too,
// so the host must clock while the reset pin is held low.
`include "sbt_defs.svh"

module sbt_dev
	import sbt_pkg::*;
(
	sbt_if.dev lnk,
	input wire logic cal_en,
	output logic inst_valid,
	output sbt_instr_t inst_word,
	output logic soft_rst,
	output logic frame_err,
	output logic busy
);

	// ============================================================
	// Calibration setting crossing
	logic cal_meta_ff;
	logic cal_sync_ff;

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			cal_meta_ff <= 1'b0;
			cal_sync_ff <= 1'b0;
		end else begin
			cal_meta_ff <= cal_en;
			cal_sync_ff <= cal_meta_ff;
		end
	end

	// ============================================================
	// Frame capture
	logic in_frame_ff;
	logic [4:0] bit_cnt_ff;
	sbt_instr_t shift_ff;
	logic frame_end;
	logic frame_good;

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			in_frame_ff <= 1'b0;
		end else begin
			in_frame_ff <= !lnk.cs_n;
		end
	end

	// Saturating so an overlong frame never wraps into a valid length
	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			bit_cnt_ff <= 5'h00;
		end else if (lnk.cs_n) begin
			bit_cnt_ff <= 5'h00;
		end else if (bit_cnt_ff != `SBT_BITS_OVER) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			shift_ff <= '0;
		end else if (!lnk.cs_n && bit_cnt_ff != `SBT_BITS_OVER) begin
			shift_ff <= {shift_ff[$bits(sbt_instr_t)-2:0], lnk.sdi};
		end
	end

	// First rising edge that sees select released closes the frame
	assign frame_end = lnk.cs_n && in_frame_ff;
	assign frame_good = frame_end && (bit_cnt_ff == `SBT_WORD_BITS);

	// ============================================================
	// Busy length of the closing frame
	logic [`SBT_CNT_W-1:0] req_len;
	logic [`SBT_CNT_W-1:0] req_load;
	logic req_srst;

	assign req_len = sbt_busy_cycles(shift_ff, cal_sync_ff);
	// Closing edge counts as the first
	assign req_load = req_len - `SBT_ONE_CYC;
	assign req_srst = !shift_ff.rd && shift_ff.addr == `SBT_CTRL_ADDR &&
		shift_ff.data[`SBT_SRST_BIT];

	// ============================================================
	// Busy sequencer
	sbt_dev_st_t state_ff;
	sbt_dev_st_t nxt_state;
	logic [`SBT_CNT_W-1:0] cnt_ff;
	logic [`SBT_CNT_W-1:0] nxt_cnt;
	logic [`SBT_CNT_W-1:0] cnt_dec;
	logic accept;

	// Frames during a reset sequence are dropped, the host must wait
	assign accept = frame_good && (state_ff != SBT_D_RESET);
	assign cnt_dec = (cnt_ff == 7'h00) ? 7'h00 : cnt_ff - `SBT_ONE_CYC;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_dec;
		case (state_ff)
			SBT_D_IDLE: begin
				nxt_cnt = 7'h00;
				if (accept) begin
					nxt_cnt = req_load;
					nxt_state = req_srst ? SBT_D_RESET : SBT_D_BUSY;
				end
			end
			SBT_D_BUSY: begin
				// A new frame never shortens a pending busy window
				if (accept && req_load > cnt_dec) begin
					nxt_cnt = req_load;
				end
				if (accept && req_srst) begin
					nxt_state = SBT_D_RESET;
				end else if (nxt_cnt == 7'h00) begin
					nxt_state = SBT_D_IDLE;
				end
			end
			SBT_D_RESET: begin
				if (cnt_dec == 7'h00) begin
					nxt_state = SBT_D_IDLE;
				end
			end
			default: begin
				nxt_state = SBT_D_IDLE;
				nxt_cnt = 7'h00;
			end
		endcase
	end

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			state_ff <= SBT_D_RESET;
			cnt_ff <= `SBT_RST_CYC;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// ============================================================
	// Open-drain busy pin
	logic busy_ff;

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			busy_ff <= 1'b1;
		end else begin
			busy_ff <= (nxt_state != SBT_D_IDLE);
		end
	end

	assign lnk.busy_o = 1'b0;
	assign lnk.busy_oe = busy_ff;
	assign busy = busy_ff;

	// ============================================================
	// User side, serial-clock domain
	logic inst_valid_ff;
	logic soft_rst_ff;
	logic frame_err_ff;
	sbt_instr_t inst_word_ff;

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			inst_valid_ff <= 1'b0;
			soft_rst_ff <= 1'b0;
			frame_err_ff <= 1'b0;
		end else begin
			inst_valid_ff <= accept;
			soft_rst_ff <= accept && req_srst;
			// Short, long or mid-reset frames are flagged, not executed
			frame_err_ff <= frame_end && !accept;
		end
	end

	always_ff @(posedge lnk.sclk) begin
		if (!lnk.hw_rst_n) begin
			inst_word_ff <= '0;
		end else if (accept) begin
			inst_word_ff <= shift_ff;
		end
	end

	assign inst_valid = inst_valid_ff;
	assign soft_rst = soft_rst_ff;
	assign frame_err = frame_err_ff;
	assign inst_word = inst_word_ff;

endmodule

// ==== src/sbt_host.sv ====
// Host end: divides clk_sys into the serial clock, sends one word per
// command and keeps the clock alive until the device is done.
// Assumes cmd_word stays steady only in the cycle it is taken.
`include "sbt_defs.svh"

module sbt_host
	import sbt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	sbt_if.host lnk,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sbt_instr_t cmd_word,
	input wire logic hw_reset_req,
	output logic link_busy,
	output logic done
);

	// ============================================================
	// Busy pin crossing
	logic busy_meta_ff;
	logic busy_s_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_meta_ff <= 1'b0;
			busy_s_ff <= 1'b0;
		end else begin
			busy_meta_ff <= !lnk.busy_n;
			busy_s_ff <= busy_meta_ff;
		end
	end

	// ============================================================
	// Clock divider
	sbt_host_st_t state_ff;
	logic [2:0] div_ff;
	logic sclk_ff;
	logic [`SBT_CNT_W-1:0] left_ff;
	logic [`SBT_CNT_W-1:0] gap_ff;
	logic tick;
	logic run;
	logic rise;
	logic fall;

	assign run = (state_ff != SBT_H_IDLE) || busy_s_ff ||
		(left_ff != 7'h00) || (gap_ff < `SBT_REASSERT_MIN);
	assign tick = (div_ff == 3'(`SBT_SCLK_HALF_CYC - 32'h1));
	assign rise = tick && !sclk_ff && run;
	// Always finish a high phase so the clock parks low
	assign fall = tick && sclk_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			div_ff <= 3'h0;
			sclk_ff <= 1'b0;
		end else if (tick) begin
			div_ff <= 3'h0;
			sclk_ff <= rise;
		end else begin
			div_ff <= div_ff + 3'h1;
		end
	end

	// ============================================================
	// Sequencer
	sbt_instr_t shift_ff;
	logic [4:0] bits_ff;
	logic [`SBT_CNT_W-1:0] pend_ff;
	logic [`SBT_CNT_W-1:0] hold_ff;
	logic cs_n_ff;
	logic sdi_ff;
	logic rst_pin_ff;
	logic srst_ff;
	logic take;

	assign cmd_ready = (state_ff == SBT_H_IDLE) && !hw_reset_req &&
		(gap_ff >= `SBT_REASSERT_MIN);
	assign take = cmd_ready && cmd_valid;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff <= SBT_H_RSTHOLD;
			shift_ff <= '0;
			bits_ff <= 5'h00;
			pend_ff <= 7'h00;
			hold_ff <= 7'h00;
			cs_n_ff <= 1'b1;
			sdi_ff <= 1'b0;
			rst_pin_ff <= 1'b0;
			srst_ff <= 1'b0;
		end else begin
			case (state_ff)
				SBT_H_IDLE: begin
					if (hw_reset_req) begin
						rst_pin_ff <= 1'b0;
						hold_ff <= 7'h00;
						state_ff <= SBT_H_RSTHOLD;
					end else if (take) begin
						shift_ff <= cmd_word;
						bits_ff <= 5'h00;
						pend_ff <= sbt_busy_cycles(cmd_word, 1'b1);
						srst_ff <= !cmd_word.rd && cmd_word.data[`SBT_SRST_BIT] &&
							cmd_word.addr == `SBT_CTRL_ADDR;
						state_ff <= SBT_H_LOAD;
					end
				end
				SBT_H_LOAD, SBT_H_SHIFT: begin
					if (fall && bits_ff == `SBT_WORD_BITS) begin
						cs_n_ff <= 1'b1;
						state_ff <= srst_ff ? SBT_H_RECOVER : SBT_H_IDLE;
					end else if (fall) begin
						cs_n_ff <= 1'b0;
						sdi_ff <= shift_ff.rd;
						shift_ff <= {shift_ff[$bits(sbt_instr_t)-2:0], 1'b0};
						bits_ff <= bits_ff + 5'h01;
						state_ff <= SBT_H_SHIFT;
					end
				end
				SBT_H_RSTHOLD: begin
					if (rise && hold_ff != `SBT_HRST_EDGES) begin
						hold_ff <= hold_ff + `SBT_ONE_CYC;
					end else if (fall && hold_ff == `SBT_HRST_EDGES) begin
						rst_pin_ff <= 1'b1;
						state_ff <= SBT_H_RECOVER;
					end
				end
				SBT_H_RECOVER: begin
					if (left_ff == 7'h00 && !busy_s_ff) begin
						state_ff <= SBT_H_IDLE;
					end
				end
				default: begin
					state_ff <= SBT_H_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Edge counters after release
	logic rel_cs;
	logic rel_rst;

	assign rel_cs = fall && bits_ff == `SBT_WORD_BITS &&
		(state_ff == SBT_H_SHIFT);
	assign rel_rst = fall && hold_ff == `SBT_HRST_EDGES &&
		(state_ff == SBT_H_RSTHOLD);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			left_ff <= 7'h00;
		end else if (rel_cs) begin
			left_ff <= pend_ff;
		end else if (rel_rst) begin
			left_ff <= `SBT_RST_CYC;
		end else if (rise && left_ff != 7'h00) begin
			left_ff <= left_ff - `SBT_ONE_CYC;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			gap_ff <= 7'h00;
		end else if (rel_cs || !cs_n_ff) begin
			gap_ff <= 7'h00;
		end else if (rise && gap_ff < `SBT_REASSERT_MIN) begin
			gap_ff <= gap_ff + `SBT_ONE_CYC;
		end
	end

	// ============================================================
	// Status
	logic link_busy_ff;
	logic done_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			link_busy_ff <= 1'b1;
			done_ff <= 1'b0;
		end else begin
			link_busy_ff <= busy_s_ff || (left_ff != 7'h00);
			done_ff <= link_busy_ff && !(busy_s_ff || (left_ff != 7'h00));
		end
	end

	assign link_busy = link_busy_ff;
	assign done = done_ff;
	assign lnk.sclk = sclk_ff;
	assign lnk.cs_n = cs_n_ff;
	assign lnk.sdi = sdi_ff;
	assign lnk.hw_rst_n = rst_pin_ff;

endmodule

// ==== dv/sbt_asserts.sv ====
// Link checker: open-drain busy, frame shape, busy window lengths.
// Assumes it is wired to the link interface signals and clk_sys.
module sbt_link_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic hw_rst_n,
	input wire logic busy_o,
	input wire logic busy_oe,
	input wire logic busy_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// ============================================================
	// Helper counters
	logic [6:0] rst_cnt_ff;
	logic [6:0] busy_cnt_ff;
	logic [4:0] low_cnt_ff;
	logic [3:0] stall_ff;
	logic sclk_d_ff;

	// Saturate so a long idle never wraps into the reset window
	always_ff @(posedge sclk) begin
		if (!hw_rst_n)
			rst_cnt_ff <= 7'h00;
		else if (rst_cnt_ff != 7'h7F)
			rst_cnt_ff <= rst_cnt_ff + 7'h01;
	end

	always_ff @(posedge sclk) begin
		if (!hw_rst_n || !busy_oe)
			busy_cnt_ff <= 7'h00;
		else if (busy_cnt_ff != 7'h7F)
			busy_cnt_ff <= busy_cnt_ff + 7'h01;
	end

	always_ff @(posedge sclk) begin
		if (!hw_rst_n || cs_n)
			low_cnt_ff <= 5'h00;
		else if (low_cnt_ff != 5'h1F)
			low_cnt_ff <= low_cnt_ff + 5'h01;
	end

	always_ff @(posedge clk_sys) begin
		sclk_d_ff <= sclk;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || sclk != sclk_d_ff)
			stall_ff <= 4'h0;
		else if (stall_ff != 4'hF)
			stall_ff <= stall_ff + 4'h1;
	end

	// ============================================================
	// Link properties
	busy_sink_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) busy_oe |-> !busy_o && !busy_n
	) else $error("busy line not pulled low while enabled");
	pull_up_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) !busy_oe |-> busy_n
	) else $error("busy line low while released");
	busy_start_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) $rose(cs_n) |=> busy_oe
	) else $error("busy missing after frame close");
	min_busy_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) $rose(busy_oe) |-> busy_oe[*2]
	) else $error("busy window shorter than three edges");
	max_busy_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) busy_cnt_ff <= 7'h40
	) else $error("busy window longer than 64 edges");
	rst_hold_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) rst_cnt_ff < 7'h40 |-> busy_oe
	) else $error("busy released early after reset");
	rst_end_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) rst_cnt_ff == 7'h40 |-> !busy_oe
	) else $error("busy held past 64 edges after reset");
	rst_wait_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) rst_cnt_ff < 7'h40 |-> cs_n
	) else $error("select during reset window");
	frame_bits_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n)
		$rose(cs_n) |-> low_cnt_ff == 5'h1A
	) else $error("frame not 26 bits");
	reselect_gap_a: assert property (
		@(posedge sclk) disable iff (!hw_rst_n) $rose(cs_n) |-> cs_n[*4]
	) else $error("select reasserted too soon");
	clock_alive_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n) !busy_n |-> stall_ff <= 4'h6
	) else $error("serial clock stopped while busy");

	cover property (@(posedge sclk) disable iff (!hw_rst_n)
		$rose(busy_oe) ##1 busy_oe[*8]);
	cover property (@(posedge sclk) disable iff (!hw_rst_n) $fell(busy_oe));
	cover property (@(posedge sclk) disable iff (!hw_rst_n)
		rst_cnt_ff == 7'h40);
endmodule

// ==== dv/spi_busy_cycle_tracker_test.sv ====
// Bench: host and device ends joined over the link interface.
// Assumes the package, interface and both ends are compiled first.
module spi_busy_cycle_tracker_test
	import sbt_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic cmd_valid = 1'h0;
	logic hw_reset_req = 1'h0;
	logic cal_en = 1'h0;
	sbt_instr_t cmd_word = '0;
	logic cmd_ready, link_busy, done, inst_valid, soft_rst, frame_err, busy;
	sbt_instr_t inst_word;
	int n_mismatch = 0;
	int n_compared = 0;
	logic [31:0] rng = 32'h5F;
	sbt_instr_t exp_q[$];
	logic [6:0] len_q[$];
	logic [6:0] run_len = 7'h00;
	logic [6:0] len_exp = 7'h00;
	logic len_pend = 1'h0;
	// Level writes at both ends of the block, reads, resets, NOP
	localparam logic [25:0] CASES [12] = '{26'h1800000, 26'h385A5A5,
		26'h1901234, 26'h081FFFF, 26'h10E0001, 26'h1878000, 26'h18E5555,
		26'h08F4321, 26'h00300F0, 26'h0920001, 26'h2120001, 26'h0920002};

	always #4 clk_sys = ~clk_sys;

	sbt_if i_sbt_if ();
	sbt_host i_sbt_host (.clk_sys(clk_sys), .rst_n(rst_n),
		.lnk(i_sbt_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_word(cmd_word), .hw_reset_req(hw_reset_req),
		.link_busy(link_busy), .done(done));
	sbt_dev i_sbt_dev (.lnk(i_sbt_if.dev), .cal_en(cal_en),
		.inst_valid(inst_valid), .inst_word(inst_word), .soft_rst(soft_rst),
		.frame_err(frame_err), .busy(busy));
	sbt_link_asserts i_sbt_link_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
		.sclk(i_sbt_if.sclk), .cs_n(i_sbt_if.cs_n),
		.hw_rst_n(i_sbt_if.hw_rst_n), .busy_o(i_sbt_if.busy_o),
		.busy_oe(i_sbt_if.busy_oe), .busy_n(i_sbt_if.busy_n));

	// ============================================================
	// Helpers
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [6:0] exp_len(input sbt_instr_t w, input logic c);
		if (!w.rd && w.addr == 7'h12 && w.data[0])
			return 7'h40;
		if (w.rd || w.addr < 7'h01 || w.addr > 7'h0E || w.ch == 2'h0)
			return 7'h03;
		if (w.ch == 2'h3)
			return c ? 7'h1A : 7'h10;
		return c ? 7'h14 : 7'h0A;
	endfunction

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tally(input string nm, input logic bad,
		input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (bad) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic cmp_word(input string nm, input sbt_instr_t e,
		input sbt_instr_t g);
		tally(nm, g !== e, 32'(e), 32'(g));
	endtask

	task automatic cmp_len(input string nm, input logic [6:0] e,
		input logic [6:0] g);
		tally(nm, g !== e, 32'(e), 32'(g));
	endtask

	task automatic cmp_bit(input string nm, input logic e, input logic g);
		tally(nm, g !== e, 32'(e), 32'(g));
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	// Every wait is bounded; a hang ends the run as a failure
	task automatic wait_for(input logic which);
		int i;
		for (i = 0; i < 4000 && (which ? done : cmd_ready) !== 1'h1; i++)
			tick();
		if (i == 4000) begin
			tally("handshake", 1'h1, 32'h1, 32'h0);
			wrap_up();
		end
	endtask

	task automatic send(input sbt_instr_t w);
		wait_for(1'h0);
		exp_q.push_back(w);
		len_q.push_back(exp_len(w, cal_en));
		cmd_valid = 1'h1;
		cmd_word = w;
		tick();
		cmd_valid = 1'h0;
		wait_for(1'h1);
		// Predicted edges and synced busy must both be spent by done
		cmp_bit("link_busy", 1'h0, link_busy);
	endtask

	// ============================================================
	// Monitor
	always @(posedge i_sbt_if.sclk) begin
		if (inst_valid === 1'h1) begin
			cmp_word("inst_word", exp_q.pop_front(), inst_word);
			len_exp = len_q.pop_front();
			cmp_bit("soft_rst", len_exp == 7'h40, soft_rst);
			len_pend = 1'h1;
		end
		if (frame_err !== 1'h0 && i_sbt_if.hw_rst_n === 1'h1)
			cmp_bit("frame_err", 1'h0, frame_err);
		run_len <= (inst_valid === 1'h1) ? 7'h01 : run_len + 7'h01;
	end

	always @(negedge busy) begin
		#1;
		if (len_pend) begin
			len_pend = 1'h0;
			cmp_len("busy_len", len_exp - 7'h01, run_len);
			cmp_bit("busy_n", 1'h1, i_sbt_if.busy_n);
		end
	end

	// ============================================================
	// Main sequence
	initial begin
		logic [31:0] r;
		repeat (6) tick();
		rst_n = 1'h1;
		for (int c = 0; c < 2; c++) begin
			cal_en = c[0];
			for (int k = 0; k < 12; k++) begin
				send(CASES[k]);
				$display("test cal %0d case %0d done", c, k);
			end
		end
		wait_for(1'h0);
		hw_reset_req = 1'h1;
		tick();
		hw_reset_req = 1'h0;
		repeat (4) tick();
		wait_for(1'h0);
		$display("test hardware reset done");
		for (int k = 0; k < 8; k++) begin
			r = xs();
			cal_en = r[31];
			send(r[25:0]);
			$display("test random %0d done", k);
		end
		repeat (200) tick();
		cmp_len("pending", 7'h00, 7'(exp_q.size()));
		wrap_up();
	end
endmodule
